// File: rtl/awm_block_write.sv
// block-mode sector write command interpreter with task file registers
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module awm_block_write
  import awm_pkg::*;
#(
  parameter int         MULT_MAX = MULT_DEFAULT,
  parameter logic [7:0] SPT      = 8'h3F,
  parameter logic [4:0] HEADS    = 5'h10
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             irq,
  output logic             media_valid,
  output logic             media_last,
  output logic      [15:0] media_data,
  output logic      [47:0] media_addr,
  input  wire logic        media_ack,
  input  wire logic        media_fail
);
  localparam int BAW = $clog2(MULT_MAX * SECTOR_WORDS);

  awm_state_type state;
  awm_state_type next_state;

  logic [7:0]  cnt_cur;
  logic [7:0]  cnt_prev;
  logic [7:0]  sec_cur;
  logic [7:0]  sec_prev;
  logic [7:0]  cyl_lo_cur;
  logic [7:0]  cyl_lo_prev;
  logic [7:0]  cyl_hi_cur;
  logic [7:0]  cyl_hi_prev;
  logic [7:0]  dev_head;
  logic        hob;
  logic [7:0]  mult_size;
  logic [7:0]  err_reg;
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] irq_mask;

  logic        ext;
  logic        lba;
  logic [47:0] addr;
  logic [47:0] rep_addr;
  logic [16:0] remaining;
  logic [7:0]  blk_left;
  logic [BAW-1:0] wptr;
  logic [BAW-1:0] rptr;
  logic [WORD_CNT_W-1:0] wcnt;
  logic        failed;
  logic        rd_pend;
  logic [15:0] buf_rdata;
  logic [15:0] rd_val;
  logic [7:0]  status_val;

  function automatic logic [7:0] blk_of(input logic [16:0] n,
                                        input logic [7:0]  m);
    return (n < {9'h000, m}) ? n[7:0] : m;
  endfunction : blk_of

  // chs walks sector 1..SPT, then head, then cylinder
  function automatic logic [47:0] next_addr(input logic [47:0] a,
                                            input logic        lin);
    logic [47:0] n;
    n = a;
    if (lin) begin
      n = a + 48'h1;
    end else if (a[7:0] < SPT) begin
      n[7:0] = a[7:0] + 8'h01;
    end else begin
      n[7:0] = 8'h01;
      if ({1'b0, a[27:24]} < HEADS - 5'h01) begin
        n[27:24] = a[27:24] + 4'h1;
      end else begin
        n[27:24] = 4'h0;
        n[23:8]  = a[23:8] + 16'h0001;
      end
    end
    return n;
  endfunction : next_addr

  wire idle      = (state == ST_IDLE);
  wire busy      = (state == ST_SEND) || (state == ST_ACK)
                   || (state == ST_DONE);
  wire wr_data   = reg_wr && (reg_addr == REG_DATA) && (state == ST_RECV);
  wire wr_cmd    = reg_wr && (reg_addr == REG_COMMAND) && idle;
  wire wr_tf     = reg_wr && idle;
  wire is_c28    = (reg_wdata[7:0] == OP_WR_MULT);
  wire is_c48    = (reg_wdata[7:0] == OP_WR_MULT_EXT);
  wire mult_ok   = (mult_size != 8'h00) && (mult_size <= 8'(MULT_MAX));
  wire cmd_ok    = wr_cmd && (is_c28 || is_c48) && mult_ok;
  wire cmd_abort = wr_cmd && !cmd_ok;

  // a zero count selects the largest transfer of each form
  wire [16:0] cnt28 = (cnt_cur == 8'h00) ? 17'(COUNT28_ZERO)
                      : {9'h000, cnt_cur};
  wire [15:0] cnt16 = {cnt_prev, cnt_cur};
  wire [16:0] cnt48 = (cnt16 == 16'h0000) ? 17'(COUNT48_ZERO)
                      : {1'b0, cnt16};
  wire [16:0] start_cnt = is_c48 ? cnt48 : cnt28;
  // chs packs sector 7:0, cylinder 23:8, head 27:24 like logical mode
  wire [47:0] start28 = {20'h00000, dev_head[3:0], cyl_hi_cur,
                         cyl_lo_cur, sec_cur};
  wire [47:0] start48 = {cyl_hi_prev, cyl_lo_prev, sec_prev,
                         cyl_hi_cur, cyl_lo_cur, sec_cur};
  wire [47:0] start_addr = is_c48 ? start48 : start28;

  wire [BAW-1:0] blk_last = BAW'(int'(blk_left) * SECTOR_WORDS - 1);
  wire recv_end  = wr_data && (wptr == blk_last);
  wire sect_end  = (state == ST_SEND)
                   && (wcnt == WORD_CNT_W'(SECTOR_WORDS - 1));
  wire ack_ok    = (state == ST_ACK) && media_ack && !media_fail;
  wire ack_bad   = (state == ST_ACK) && media_ack && media_fail;
  wire blk_end   = ack_ok && (blk_left == 8'h01);
  wire all_end   = blk_end && (remaining == 17'h00001);
  wire [16:0] rem_dec = remaining - 17'h00001;

  // interrupt only between blocks and at the end, never per sector
  wire ev_block = blk_end && !all_end;
  wire ev_done  = (state == ST_DONE) || cmd_abort;
  wire ev_err   = ack_bad || cmd_abort;
  wire [IRQ_W-1:0] irq_ev  = {ev_err, ev_done, ev_block};
  wire [IRQ_W-1:0] irq_clr = (reg_wr && reg_addr == REG_IRQ_ST)
                             ? reg_wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_st = (irq_st & ~irq_clr) | irq_ev;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (cmd_ok) next_state = ST_RECV;
      ST_RECV: if (recv_end) next_state = ST_SEND;
      ST_SEND: if (sect_end) next_state = ST_ACK;
      ST_ACK: begin
        if (ack_bad || all_end) begin
          next_state = ST_DONE;
        end else if (blk_end) begin
          next_state = ST_RECV;
        end else if (ack_ok) begin
          next_state = ST_SEND;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // transfer engine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      ext       <= 1'b0;
      lba       <= 1'b0;
      addr      <= '0;
      rep_addr  <= '0;
      remaining <= '0;
      blk_left  <= '0;
      wptr      <= '0;
      rptr      <= '0;
      wcnt      <= '0;
      failed    <= 1'b0;
    end else begin
      state <= next_state;
      if (cmd_ok) begin
        ext       <= is_c48;
        lba       <= is_c48 || dev_head[DH_LBA];
        addr      <= start_addr;
        remaining <= start_cnt;
        blk_left  <= blk_of(start_cnt, mult_size);
        wptr      <= '0;
        failed    <= 1'b0;
      end
      if (wr_data) begin
        wptr <= wptr + BAW'(1);
      end
      if (recv_end) begin
        rptr <= '0;
        wcnt <= '0;
      end
      if (state == ST_SEND) begin
        rptr <= rptr + BAW'(1);
        wcnt <= wcnt + WORD_CNT_W'(1);
      end
      if (ack_bad) begin
        rep_addr <= addr;
        failed   <= 1'b1;
      end
      if (ack_ok) begin
        rep_addr  <= addr;
        addr      <= next_addr(addr, lba);
        remaining <= rem_dec;
        blk_left  <= blk_left - 8'h01;
      end
      if (ev_block) begin
        blk_left <= blk_of(rem_dec, mult_size);
        wptr     <= '0;
      end
    end
  end

  // media sees each word of a sector, then answers once per sector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend     <= 1'b0;
      media_valid <= 1'b0;
      media_last  <= 1'b0;
      media_addr  <= '0;
    end else begin
      rd_pend     <= (state == ST_SEND);
      media_valid <= (state == ST_SEND);
      media_last  <= sect_end;
      media_addr  <= addr;
    end
  end

  assign media_data = buf_rdata;

  awm_sector_buf #(
    .DW (16),
    .AW (BAW)
  ) u_buf (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .we      (wr_data),
    .waddr   (wptr),
    .wdata   (reg_wdata),
    .re      (state == ST_SEND),
    .raddr   (rptr),
    .rdata   (buf_rdata)
  );

  // task file: host loads it while idle, engine writes results back
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_cur     <= '0;
      cnt_prev    <= '0;
      sec_cur     <= '0;
      sec_prev    <= '0;
      cyl_lo_cur  <= '0;
      cyl_lo_prev <= '0;
      cyl_hi_cur  <= '0;
      cyl_hi_prev <= '0;
      dev_head    <= '0;
    end else if (state == ST_DONE) begin
      cnt_cur    <= remaining[7:0];
      cnt_prev   <= remaining[15:8];
      sec_cur    <= rep_addr[7:0];
      cyl_lo_cur <= rep_addr[15:8];
      cyl_hi_cur <= rep_addr[23:16];
      if (ext) begin
        sec_prev    <= rep_addr[31:24];
        cyl_lo_prev <= rep_addr[39:32];
        cyl_hi_prev <= rep_addr[47:40];
      end else begin
        dev_head[3:0] <= rep_addr[27:24];
      end
    end else if (wr_tf) begin
      // each count, sector or cylinder write pushes the old byte into the previous slot
      if (reg_addr == REG_COUNT) begin
        cnt_prev <= cnt_cur;
        cnt_cur  <= reg_wdata[7:0];
      end else if (reg_addr == REG_SECTOR) begin
        sec_prev <= sec_cur;
        sec_cur  <= reg_wdata[7:0];
      end else if (reg_addr == REG_CYL_LO) begin
        cyl_lo_prev <= cyl_lo_cur;
        cyl_lo_cur  <= reg_wdata[7:0];
      end else if (reg_addr == REG_CYL_HI) begin
        cyl_hi_prev <= cyl_hi_cur;
        cyl_hi_cur  <= reg_wdata[7:0];
      end else if (reg_addr == REG_DEV_HEAD) begin
        dev_head <= reg_wdata[7:0];
      end
    end
  end

  // control, error and interrupt registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hob       <= 1'b0;
      mult_size <= 8'(MULT_DEFAULT);
      err_reg   <= '0;
      irq_st    <= '0;
      irq_mask  <= '0;
      irq       <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      irq    <= |(irq_st & irq_mask);
      if (reg_wr && reg_addr == REG_DEV_CTRL) begin
        hob <= reg_wdata[CTRL_HOB];
      end
      if (reg_wr && reg_addr == REG_MULT && idle) begin
        mult_size <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == REG_IRQ_MASK) begin
        irq_mask <= reg_wdata[IRQ_W-1:0];
      end
      if (cmd_ok) begin
        err_reg <= '0;
      end else if (cmd_abort) begin
        err_reg         <= '0;
        err_reg[ER_ABT] <= 1'b1;
      end else if (state == ST_DONE) begin
        err_reg         <= '0;
        err_reg[ER_IDN] <= failed;
      end
    end
  end

  // fault and corrected-data bits are never raised by this command
  always_comb begin
    status_val         = '0;
    status_val[ST_BSY] = busy;
    status_val[ST_RDY] = 1'b1;
    status_val[ST_DF]  = 1'b0;
    status_val[ST_DSC] = 1'b1;
    status_val[ST_DRQ] = (state == ST_RECV);
    status_val[ST_COR] = 1'b0;
    status_val[ST_ERR] = |err_reg;
  end

  always_comb begin
    if (reg_addr == REG_ERROR) begin
      rd_val = {8'h00, err_reg};
    end else if (reg_addr == REG_COUNT) begin
      rd_val = {8'h00, hob ? cnt_prev : cnt_cur};
    end else if (reg_addr == REG_SECTOR) begin
      rd_val = {8'h00, hob ? sec_prev : sec_cur};
    end else if (reg_addr == REG_CYL_LO) begin
      rd_val = {8'h00, hob ? cyl_lo_prev : cyl_lo_cur};
    end else if (reg_addr == REG_CYL_HI) begin
      rd_val = {8'h00, hob ? cyl_hi_prev : cyl_hi_cur};
    end else if (reg_addr == REG_DEV_HEAD) begin
      rd_val = {8'h00, dev_head};
    end else if (reg_addr == REG_COMMAND) begin
      rd_val = {8'h00, status_val};
    end else if (reg_addr == REG_DEV_CTRL) begin
      rd_val = {8'h00, hob, 7'h00};
    end else if (reg_addr == REG_MULT) begin
      rd_val = {8'h00, mult_size};
    end else if (reg_addr == REG_IRQ_ST) begin
      rd_val = {13'h0000, irq_st};
    end else if (reg_addr == REG_IRQ_MASK) begin
      rd_val = {13'h0000, irq_mask};
    end else begin
      rd_val = '0;
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 16'h0000;
    end
  end
endmodule : awm_block_write

// File: rtl/awm_pkg.sv
// constants, register map and types of the block-mode write interpreter
package awm_pkg;
  localparam logic [3:0] REG_DATA     = 4'h0;
  localparam logic [3:0] REG_ERROR    = 4'h1;
  localparam logic [3:0] REG_COUNT    = 4'h2;
  localparam logic [3:0] REG_SECTOR   = 4'h3;
  localparam logic [3:0] REG_CYL_LO   = 4'h4;
  localparam logic [3:0] REG_CYL_HI   = 4'h5;
  localparam logic [3:0] REG_DEV_HEAD = 4'h6;
  localparam logic [3:0] REG_COMMAND  = 4'h7;
  localparam logic [3:0] REG_DEV_CTRL = 4'h8;
  localparam logic [3:0] REG_MULT     = 4'h9;
  localparam logic [3:0] REG_IRQ_ST   = 4'hA;
  localparam logic [3:0] REG_IRQ_MASK = 4'hB;

  localparam logic [7:0] OP_WR_MULT     = 8'hC5;
  localparam logic [7:0] OP_WR_MULT_EXT = 8'h39;

  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF  = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_COR = 2;
  localparam int ST_ERR = 0;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int DH_LBA = 6;
  localparam int CTRL_HOB = 7;

  localparam int IRQ_BLOCK = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_ERR   = 2;
  localparam int IRQ_W     = 3;

  localparam int SECTOR_WORDS  = 256;
  localparam int WORD_CNT_W    = 8;
  localparam int COUNT28_ZERO  = 256;
  localparam int COUNT48_ZERO  = 65536;
  localparam int MULT_DEFAULT  = 16;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_SEND, ST_ACK, ST_DONE
  } awm_state_type;
endpackage : awm_pkg

// File: rtl/awm_sector_buf.sv
// block buffer memory with registered read data
`timescale 1ns/1ps
module awm_sector_buf #(
  parameter int DW = 16,
  parameter int AW = 12
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // array has no reset so it can map onto block ram
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : awm_sector_buf

// File: tb/awm_block_write_properties.sv
// port checker for the block write interpreter
`timescale 1ns/1ps
module awm_block_write_properties
  import awm_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        irq,
  input wire logic        media_valid,
  input wire logic        media_last,
  input wire logic [15:0] media_data,
  input wire logic [47:0] media_addr,
  input wire logic        media_ack,
  input wire logic        media_fail
);
  logic [7:0] wcnt;
  logic       waiting;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // words seen so far in the sector now streaming
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wcnt    <= 8'h00;
      waiting <= 1'b0;
    end else begin
      if (media_valid) wcnt <= media_last ? 8'h00 : wcnt + 8'h01;
      if (media_last) waiting <= 1'b1;
      else if (media_ack) waiting <= 1'b0;
    end
  end
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  data_read_a: assert property ($past(reg_rd) && $past(reg_addr) == REG_DATA
    |-> reg_rdata == 16'h0000) else $error("data port read not zero");
  status_fix_a: assert property ($past(reg_rd) && $past(reg_addr) == REG_COMMAND
    |-> reg_rdata[ST_RDY] && !reg_rdata[ST_DF] && !reg_rdata[ST_COR])
    else $error("fixed status bits wrong");
  error_bits_a: assert property ($past(reg_rd) && $past(reg_addr) == REG_ERROR
    |-> (reg_rdata & 16'hFFEB) == 16'h0000)
    else $error("error flags outside not-found and abort");
  last_valid_a: assert property (media_last |-> media_valid)
    else $error("last word without valid");
  sector_len_a: assert property (media_last |-> wcnt == 8'hFF)
    else $error("sector not 256 words");
  stream_run_a: assert property (media_valid && !media_last |=> media_valid)
    else $error("sector stream broken");
  addr_hold_a: assert property (media_valid && !media_last
    |=> $stable(media_addr)) else $error("address moved in sector");
  wait_quiet_a: assert property (waiting |-> !media_valid)
    else $error("next sector before commit");
  irq_cause_a: assert property ($rose(irq) |-> $past(reg_wr, 1)
    || $past(reg_wr, 2) || $past(reg_wr, 3) || $past(media_ack, 1)
    || $past(media_ack, 2) || $past(media_ack, 3) || $past(media_ack, 4))
    else $error("interrupt without cause");
  irq_drop_a: assert property ($fell(irq) |-> $past(reg_wr, 1)
    || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("interrupt dropped by itself");
  cover property (media_ack && media_fail);
  cover property ($rose(irq));
  cover property (media_last);
endmodule : awm_block_write_properties

bind awm_block_write awm_block_write_properties u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .media_valid(media_valid),
  .media_last(media_last), .media_data(media_data),
  .media_addr(media_addr), .media_ack(media_ack), .media_fail(media_fail)
);

// File: tb/awm_media_model.sv
// media side model: commits each streamed sector after a delay
`timescale 1ns/1ps
module awm_media_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic media_valid,
  input  wire logic media_last,
  input  wire logic fail_next,
  input  wire logic slow,
  output logic      media_ack,
  output logic      media_fail
);
  logic [4:0] cnt;
  // fail line toggles outside an ack so a stale level never reads as valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 5'h00;
      media_ack  <= 1'b0;
      media_fail <= 1'b0;
    end else begin
      media_ack  <= 1'b0;
      media_fail <= ~media_fail;
      if (media_valid && media_last) cnt <= slow ? 5'h14 : 5'h02;
      else if (cnt != 5'h00) cnt <= cnt - 5'h01;
      if (cnt == 5'h01) begin
        media_ack  <= 1'b1;
        media_fail <= fail_next;
      end
    end
  end
endmodule : awm_media_model

// File: tb/tb.sv
// self-checking bench of the block write interpreter
`timescale 1ns/1ps
module tb
  import awm_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        fail_next = 1'b0;
  logic        slow = 1'b0;
  logic        chk_a = 1'b0;
  logic [7:0]  msec = 8'h00;
  logic [7:0]  mword = 8'h00;
  logic [7:0]  tx_sec = 8'h00;
  logic [47:0] exp_a = 48'h0;
  logic [15:0] v;
  wire  [15:0] reg_rdata;
  wire  [15:0] media_data;
  wire  [47:0] media_addr;
  wire         irq, media_valid, media_last, media_ack, media_fail;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  awm_block_write uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .media_valid(media_valid), .media_last(media_last),
    .media_data(media_data), .media_addr(media_addr),
    .media_ack(media_ack), .media_fail(media_fail));
  awm_media_model u_media (.clk_sys(clk_sys), .rst_n(rst_n),
    .media_valid(media_valid), .media_last(media_last),
    .fail_next(fail_next), .slow(slow), .media_ack(media_ack),
    .media_fail(media_fail));

  always #12.5 clk_sys = ~clk_sys;

  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // about 5.4k cycles expected; generous margin before calling it a hang
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdv(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdv

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rdv(a, d);
    check(d, exp);
  endtask : rd

  task automatic poll(input logic [7:0] m, input logic [7:0] val);
    int n;
    rdv(REG_COMMAND, v);
    for (n = 0; n < 4000 && (v[7:0] & m) !== val; n++) rdv(REG_COMMAND, v);
    check(v[7:0] & m, val);
  endtask : poll

  task automatic send(input int n);
    for (int s = 0; s < n; s++) begin
      for (int i = 0; i < 256; i++) wr(REG_DATA, {tx_sec, 8'(i)});
      tx_sec = tx_sec + 8'h01;
    end
  endtask : send

  task automatic start(input logic ca, input logic [47:0] a);
    chk_a  = ca;
    exp_a  = a;
    msec   = 8'h00;
    mword  = 8'h00;
    tx_sec = 8'h00;
  endtask : start

  // words leave in order; logical address steps once per sector
  always @(posedge clk_sys) begin
    if (media_valid === 1'b1) begin
      check(media_data, {msec, mword});
      if (chk_a) check(media_addr, exp_a);
      mword <= mword + 8'h01;
      if (media_last) begin
        msec  <= msec + 8'h01;
        exp_a <= exp_a + 48'h1;
      end
    end
  end

  task automatic t_reset();
    rd(REG_COMMAND, 16'h0050);
    rd(REG_MULT, 16'h0010);
    rd(REG_IRQ_MASK, 16'h0000);
    rd(4'hC, 16'h0000);
    rd(REG_ERROR, 16'h0000);
  endtask : t_reset

  task automatic t_lba28();
    wr(REG_IRQ_MASK, 16'h0007);
    wr(REG_MULT, 16'h0002);
    wr(REG_DEV_HEAD, 16'h00E1);
    wr(REG_CYL_HI, 16'h0000);
    wr(REG_CYL_LO, 16'h0012);
    wr(REG_SECTOR, 16'h00FF);
    wr(REG_COUNT, 16'h0003);
    start(1'b1, 48'h0000010012FF);
    wr(REG_COMMAND, {8'h00, OP_WR_MULT});
    poll(8'h88, 8'h08);
    send(2);
    poll(8'h88, 8'h08);
    check(irq, 1'b1);
    rd(REG_IRQ_ST, 16'h0001);
    wr(REG_IRQ_ST, 16'h0001);
    send(1);
    poll(8'h88, 8'h00);
    check(msec, 8'h03);
    rd(REG_COUNT, 16'h0000);
    rd(REG_SECTOR, 16'h0001);
    rd(REG_CYL_LO, 16'h0013);
    rd(REG_CYL_HI, 16'h0000);
    rdv(REG_DEV_HEAD, v);
    check(v[3:0], 4'h1);
    rd(REG_COMMAND, 16'h0050);
    rd(REG_IRQ_ST, 16'h0002);
    wr(REG_IRQ_ST, 16'h0007);
  endtask : t_lba28

  task automatic t_chs28();
    slow = 1'b1;
    wr(REG_MULT, 16'h0010);
    wr(REG_DEV_HEAD, 16'h00A2);
    wr(REG_CYL_HI, 16'h0000);
    wr(REG_CYL_LO, 16'h0005);
    wr(REG_SECTOR, 16'h003F);
    wr(REG_COUNT, 16'h0002);
    start(1'b0, 48'h0);
    wr(REG_COMMAND, {8'h00, OP_WR_MULT});
    poll(8'h88, 8'h08);
    send(2);
    poll(8'h88, 8'h00);
    slow = 1'b0;
    check(msec, 8'h02);
    rd(REG_SECTOR, 16'h0001);
    rdv(REG_DEV_HEAD, v);
    check(v[3:0], 4'h3);
    rd(REG_CYL_LO, 16'h0005);
    rd(REG_COUNT, 16'h0000);
    rd(REG_IRQ_ST, 16'h0002);
    wr(REG_IRQ_ST, 16'h0007);
  endtask : t_chs28

  task automatic t_ext_fail();
    wr(REG_COUNT, 16'h0001);
    wr(REG_COUNT, 16'h0000);
    wr(REG_SECTOR, 16'h0044);
    wr(REG_SECTOR, 16'h0011);
    wr(REG_CYL_LO, 16'h0055);
    wr(REG_CYL_LO, 16'h0022);
    wr(REG_CYL_HI, 16'h0066);
    wr(REG_CYL_HI, 16'h0033);
    wr(REG_DEV_HEAD, 16'h0040);
    wr(REG_MULT, 16'h0002);
    fail_next = 1'b1;
    start(1'b1, 48'h665544332211);
    wr(REG_COMMAND, {8'h00, OP_WR_MULT_EXT});
    poll(8'h88, 8'h08);
    send(2);
    poll(8'h88, 8'h00);
    fail_next = 1'b0;
    check(msec, 8'h01);
    rd(REG_ERROR, 16'h0010);
    rd(REG_COMMAND, 16'h0051);
    rd(REG_COUNT, 16'h0000);
    rd(REG_SECTOR, 16'h0011);
    rd(REG_CYL_LO, 16'h0022);
    rd(REG_CYL_HI, 16'h0033);
    wr(REG_DEV_CTRL, 16'h0080);
    rd(REG_COUNT, 16'h0001);
    rd(REG_SECTOR, 16'h0044);
    rd(REG_CYL_LO, 16'h0055);
    rd(REG_CYL_HI, 16'h0066);
    wr(REG_DEV_CTRL, 16'h0000);
    rd(REG_IRQ_ST, 16'h0006);
    wr(REG_IRQ_ST, 16'h0007);
  endtask : t_ext_fail

  task automatic t_abort();
    wr(REG_IRQ_MASK, 16'h0000);
    wr(REG_COMMAND, 16'h0020);
    rd(REG_ERROR, 16'h0004);
    rd(REG_COMMAND, 16'h0051);
    check(irq, 1'b0);
    rd(REG_IRQ_ST, 16'h0006);
    wr(REG_IRQ_MASK, 16'h0007);
    rd(REG_IRQ_MASK, 16'h0007);
    check(irq, 1'b1);
    wr(REG_IRQ_ST, 16'h0007);
    rd(REG_IRQ_ST, 16'h0000);
    check(irq, 1'b0);
  endtask : t_abort

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_lba28();
    t_chs28();
    t_ext_fail();
    t_abort();
    finish_test();
  end
endmodule : tb
